// File: hw/bcr_field_decode.sv
// field decoder for one configuration word
// assumes the caller registers the results; purely combinational
`timescale 1ns/1ps
module bcr_field_decode
    import bcr_pkg::*;
(
    input wire logic [bcr_pkg::CFG_W-1:0] cfg,
    output logic [2:0] drive_code,
    output logic [1:0] sector_map,
    output logic [4:0] latency_clks,
    output logic stall_on_dual_err,
    output logic ssr_locked,
    output logic [6:0] wrap_bytes,
    output logic wrap_legacy,
    output logic burst_reserved
);

    // fixed-position fields
    always_comb
    begin
        drive_code = cfg[DRV_HI:DRV_LO];
        sector_map = cfg[MAP_HI:MAP_LO];
        latency_clks = {1'b0, cfg[LAT_HI:LAT_LO]} + LAT_BASE;
        stall_on_dual_err = ~cfg[BIT_STALL];
        ssr_locked = ~cfg[BIT_SSR];
    end

    // burst length; 16 and 32 keep the old wrap, 64 has its own order
    always_comb
    begin
        wrap_bytes = WRAP_BYTES_NONE;
        wrap_legacy = 1'b0;
        burst_reserved = 1'b0;
        unique case (cfg[BURST_HI:BURST_LO])
            BURST_RSVD:
            begin
                burst_reserved = 1'b1;
            end
            BURST_64:
            begin
                wrap_bytes = WRAP_BYTES_64;
            end
            BURST_16:
            begin
                wrap_bytes = WRAP_BYTES_16;
                wrap_legacy = 1'b1;
            end
            BURST_32:
            begin
                wrap_bytes = WRAP_BYTES_32;
                wrap_legacy = 1'b1;
            end
        endcase
    end

endmodule : bcr_field_decode

// File: hw/bcr_pkg.sv
// constants, field layout and lock states of the bus configuration register pair
// assumes a 16-bit configuration word and a small word-indexed register port
package bcr_pkg;

    // widths
    localparam int CFG_W = 16;
    localparam int ADDR_W = 3;

    // register offsets on the plain register port
    localparam logic [2:0] OFF_NV_CFG = 3'h0;
    localparam logic [2:0] OFF_VOL_CFG = 3'h1;
    localparam logic [2:0] OFF_STATUS = 3'h2;
    localparam logic [2:0] OFF_ACTIVE_CFG = 3'h3;
    localparam logic [2:0] OFF_NV_ERASE = 3'h4;

    // field positions, identical in both configuration words
    localparam int BIT_RSVD_HI = 15;
    localparam int DRV_HI = 14;
    localparam int DRV_LO = 12;
    localparam int BIT_FREEZE = 11;
    localparam int BIT_SSR = 10;
    localparam int MAP_HI = 9;
    localparam int MAP_LO = 8;
    localparam int LAT_HI = 7;
    localparam int LAT_LO = 4;
    localparam int BIT_RSVD_LO = 3;
    localparam int BIT_STALL = 2;
    localparam int BURST_HI = 1;
    localparam int BURST_LO = 0;

    // reset and fixed values
    localparam logic [15:0] CFG_FACTORY = 16'h8EBB;
    localparam logic [15:0] CFG_ERASED = 16'hFFFF;
    localparam logic [15:0] CFG_RSVD_MASK = 16'h8008;
    localparam logic [15:0] RDATA_IDLE = 16'h0000;

    // latency is the code plus this many clocks
    localparam logic [4:0] LAT_BASE = 5'h05;

    // burst length codes and wrap sizes in bytes
    localparam logic [1:0] BURST_RSVD = 2'h0;
    localparam logic [1:0] BURST_64 = 2'h1;
    localparam logic [1:0] BURST_16 = 2'h2;
    localparam logic [1:0] BURST_32 = 2'h3;
    localparam logic [6:0] WRAP_BYTES_16 = 7'h10;
    localparam logic [6:0] WRAP_BYTES_32 = 7'h20;
    localparam logic [6:0] WRAP_BYTES_64 = 7'h40;
    localparam logic [6:0] WRAP_BYTES_NONE = 7'h00;

    // status word bit positions
    localparam int ST_SEL = 0;
    localparam int ST_LOADED = 1;
    localparam int ST_LOCK_LO = 2;
    localparam int ST_LOCK_HI = 3;
    localparam int ST_REFUSED = 4;
    localparam int ST_SSR = 5;

    // lock state, gray along unlocked -> temporary -> permanent
    typedef enum logic [1:0]
    {
        BCR_UNLOCKED = 2'b00,
        BCR_TEMP_LOCK = 2'b01,
        BCR_PERM_LOCK = 2'b11
    } bcr_lock_t;

endpackage : bcr_pkg

// File: hw/bcr_top.sv
// bus configuration register pair: nonvolatile and volatile copies, source
// selection, freeze handling and decoded bus characteristics
// assumes all inputs come from logic on CLK; register port answers reads
// one cycle later and never stalls
//
// Function
// - reset takes bus settings from nonvolatile copy
// - volatile load switches source; only reset reverts
// - volatile copy changes only while idle, unlocked
// - reserved bits 15 and 3 stay one
// - bits 14:12 give eight-step drive code
// - freeze bit zero locks both copies
// - bit 10 zero locks secure silicon region
// - bits 9:8 select sector map
// - bits 7:4 give latency code plus five
// - bit 2 zero selects strobe stall on dual error
// - bits 1:0 give wrapped burst length
// - both copies share one bit layout
// - after reset freeze bits define lock state
// - 16/32 wrap legacy, 64 wrap own order
// - software reset keeps register source selection
// - nonvolatile program loads unloaded volatile copy only
// - nonvolatile change acts only after reset
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
module bcr_top
    import bcr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic NV_INIT_N,
    input wire logic SW_RESET,
    input wire logic DEV_IDLE,
    input wire logic [bcr_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [bcr_pkg::CFG_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [bcr_pkg::CFG_W-1:0] REG_RDATA,
    output logic CFG_FROM_VOLATILE,
    output logic CFG_LOCKED,
    output logic SECURE_REGION_LOCKED,
    output logic [2:0] DRIVE_CODE,
    output logic [1:0] SECTOR_MAP,
    output logic [4:0] READ_LATENCY_CLKS,
    output logic STROBE_STALL_ON_DUAL_ERR,
    output logic [6:0] WRAP_BYTES,
    output logic WRAP_LEGACY,
    output logic BURST_RESERVED
);

    import bcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // reserved bits are forced high so no host slip can clear them
    function automatic logic [CFG_W-1:0] bcr_sanitize(input logic [CFG_W-1:0] word);
        bcr_sanitize = word | CFG_RSVD_MASK;
    endfunction : bcr_sanitize

    ////////////////////////////////////////////////////////////////////////////
    // storage and control state

    logic [CFG_W-1:0] nv_cell_r;
    logic [CFG_W-1:0] nv_boot_r;
    logic [CFG_W-1:0] vol_cfg_r;
    logic vol_loaded_r;
    logic sel_vol_r;
    bcr_lock_t lock_r;
    logic locked_r;
    logic refused_r;
    logic [CFG_W-1:0] rdata_r;

    // decoded outputs, all registered
    logic [2:0] drive_r;
    logic [1:0] map_r;
    logic [4:0] lat_r;
    logic stall_r;
    logic ssr_r;
    logic [6:0] wrap_r;
    logic legacy_r;
    logic burst_bad_r;

    // combinational results
    logic [CFG_W-1:0] active_cfg;
    logic [2:0] drive_nxt;
    logic [1:0] map_nxt;
    logic [4:0] lat_nxt;
    logic stall_nxt;
    logic ssr_nxt;
    logic [6:0] wrap_nxt;
    logic legacy_nxt;
    logic burst_bad_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // access qualification

    logic wr_vol;
    logic wr_nv;
    logic erase_nv;
    logic change_req;
    logic change_ok;

    // a change needs an idle device and no freeze in force
    always_comb
    begin
        wr_vol = REG_WR && (REG_ADDR == OFF_VOL_CFG);
        wr_nv = REG_WR && (REG_ADDR == OFF_NV_CFG);
        erase_nv = REG_WR && (REG_ADDR == OFF_NV_ERASE);
        change_req = wr_vol || wr_nv || erase_nv;
        change_ok = DEV_IDLE && (lock_r == BCR_UNLOCKED);
    end

    ////////////////////////////////////////////////////////////////////////////
    // nonvolatile cell

    // the cell survives RST_N; NV_INIT_N stands for the factory state
    always_ff @(posedge CLK)
    begin
        if (!NV_INIT_N)
        begin
            nv_cell_r <= CFG_FACTORY;
        end
        else if (change_ok && wr_nv)
        begin
            nv_cell_r <= bcr_sanitize(REG_WDATA);
        end
        else if (change_ok && erase_nv)
        begin
            nv_cell_r <= CFG_ERASED;
        end
        // locked or busy attempts fall through and keep the cell
    end

    // behaviour copy of the cell, refreshed only at reset
    always_ff @(posedge CLK)
    begin
        if (!NV_INIT_N)
        begin
            nv_boot_r <= CFG_FACTORY;
        end
        else if (!RST_N)
        begin
            nv_boot_r <= nv_cell_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // volatile copy

    // reset mirrors the cell; a program follows through only if never loaded
    always_ff @(posedge CLK)
    begin
        if (!NV_INIT_N)
        begin
            vol_cfg_r <= CFG_FACTORY;
        end
        else if (!RST_N)
        begin
            vol_cfg_r <= nv_cell_r;
        end
        else if (change_ok && wr_vol)
        begin
            vol_cfg_r <= bcr_sanitize(REG_WDATA);
        end
        else if (change_ok && wr_nv && !vol_loaded_r)
        begin
            vol_cfg_r <= bcr_sanitize(REG_WDATA);
        end
        else if (change_ok && erase_nv && !vol_loaded_r)
        begin
            vol_cfg_r <= CFG_ERASED;
        end
        // a loaded copy ignores later nonvolatile changes
    end

    // loaded flag and source select; software reset has no say here
    always_ff @(posedge CLK)
    begin
        if (!NV_INIT_N || !RST_N)
        begin
            vol_loaded_r <= 1'b0;
            sel_vol_r <= 1'b0;
        end
        else if (change_ok && wr_vol)
        begin
            vol_loaded_r <= 1'b1;
            sel_vol_r <= 1'b1;
        end
        // SW_RESET intentionally leaves the select alone
    end

    ////////////////////////////////////////////////////////////////////////////
    // lock state

    // at reset the copies are equal, so freeze 0 means permanent, 1 means free;
    // a volatile load with freeze 0 gives the temporary lock until next reset;
    // locked_r tracks lock_r as its own flop so the pin needs no decode gate
    always_ff @(posedge CLK)
    begin
        if (!NV_INIT_N)
        begin
            lock_r <= BCR_UNLOCKED;
            locked_r <= 1'b0;
        end
        else if (!RST_N)
        begin
            lock_r <= nv_cell_r[BIT_FREEZE] ? BCR_UNLOCKED : BCR_PERM_LOCK;
            locked_r <= !nv_cell_r[BIT_FREEZE];
        end
        else if (change_ok && wr_vol && !REG_WDATA[BIT_FREEZE])
        begin
            lock_r <= BCR_TEMP_LOCK;
            locked_r <= 1'b1;
        end
    end

    // refused flag: set by a refused change, cleared by an accepted one
    always_ff @(posedge CLK)
    begin
        if (!NV_INIT_N || !RST_N)
        begin
            refused_r <= 1'b0;
        end
        else if (change_req)
        begin
            refused_r <= !change_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // active settings

    // one decoder serves either copy, since the layout is shared
    assign active_cfg = sel_vol_r ? vol_cfg_r : nv_boot_r;

    bcr_field_decode u_decode
    (
        .cfg(active_cfg),
        .drive_code(drive_nxt),
        .sector_map(map_nxt),
        .latency_clks(lat_nxt),
        .stall_on_dual_err(stall_nxt),
        .ssr_locked(ssr_nxt),
        .wrap_bytes(wrap_nxt),
        .wrap_legacy(legacy_nxt),
        .burst_reserved(burst_bad_nxt)
    );

    // register the decoded fields; they trail the active word by one clock
    always_ff @(posedge CLK)
    begin
        if (!NV_INIT_N || !RST_N)
        begin
            drive_r <= CFG_FACTORY[DRV_HI:DRV_LO];
            map_r <= CFG_FACTORY[MAP_HI:MAP_LO];
            lat_r <= LAT_BASE;
            stall_r <= 1'b1;
            ssr_r <= 1'b0;
            wrap_r <= WRAP_BYTES_NONE;
            legacy_r <= 1'b0;
            burst_bad_r <= 1'b0;
        end
        else
        begin
            drive_r <= drive_nxt;
            map_r <= map_nxt;
            lat_r <= lat_nxt;
            stall_r <= stall_nxt;
            ssr_r <= ssr_nxt;
            wrap_r <= wrap_nxt;
            legacy_r <= legacy_nxt;
            burst_bad_r <= burst_bad_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port

    // data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge CLK)
    begin
        if (!NV_INIT_N || !RST_N)
        begin
            rdata_r <= RDATA_IDLE;
        end
        else if (REG_RD)
        begin
            unique case (REG_ADDR)
                OFF_NV_CFG:
                begin
                    rdata_r <= nv_cell_r;
                end
                OFF_VOL_CFG:
                begin
                    rdata_r <= vol_cfg_r;
                end
                OFF_STATUS:
                begin
                    rdata_r <= RDATA_IDLE;
                    rdata_r[ST_SEL] <= sel_vol_r;
                    rdata_r[ST_LOADED] <= vol_loaded_r;
                    rdata_r[ST_LOCK_HI:ST_LOCK_LO] <= lock_r;
                    rdata_r[ST_REFUSED] <= refused_r;
                    rdata_r[ST_SSR] <= ssr_r;
                end
                OFF_ACTIVE_CFG:
                begin
                    rdata_r <= active_cfg;
                end
                default:
                begin
                    rdata_r <= RDATA_IDLE; // unmapped and erase offsets read zero
                end
            endcase
        end
        else
        begin
            rdata_r <= RDATA_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // every pin is a plain flop copy, so no gate sits between register and pin
    assign REG_RDATA = rdata_r;
    assign CFG_FROM_VOLATILE = sel_vol_r;
    assign CFG_LOCKED = locked_r;
    assign SECURE_REGION_LOCKED = ssr_r;
    assign DRIVE_CODE = drive_r;
    assign SECTOR_MAP = map_r;
    assign READ_LATENCY_CLKS = lat_r;
    assign STROBE_STALL_ON_DUAL_ERR = stall_r;
    assign WRAP_BYTES = wrap_r;
    assign WRAP_LEGACY = legacy_r;
    assign BURST_RESERVED = burst_bad_r;

endmodule : bcr_top

// File: testbench/bcr_checker_properties.sv
// concurrent checks on the ports of the configuration register pair
// assumes one clock domain; both resets are synchronous, active low
`timescale 1ns/1ps
module bcr_checker
    import bcr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic NV_INIT_N,
    input wire logic SW_RESET,
    input wire logic DEV_IDLE,
    input wire logic [bcr_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [bcr_pkg::CFG_W-1:0] REG_RDATA,
    input wire logic CFG_FROM_VOLATILE,
    input wire logic CFG_LOCKED,
    input wire logic SECURE_REGION_LOCKED,
    input wire logic [2:0] DRIVE_CODE,
    input wire logic [1:0] SECTOR_MAP,
    input wire logic [4:0] READ_LATENCY_CLKS,
    input wire logic STROBE_STALL_ON_DUAL_ERR,
    input wire logic [6:0] WRAP_BYTES,
    input wire logic WRAP_LEGACY,
    input wire logic BURST_RESERVED
);
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N || !NV_INIT_N);
    // reading the active word shows what the decoded outputs must hold next cycle
    wire act_rd = REG_RD && REG_ADDR == OFF_ACTIVE_CFG;
    wire vol_wr = REG_WR && REG_ADDR == OFF_VOL_CFG;

    a_drive_code: assert property (act_rd |=> DRIVE_CODE == REG_RDATA[14:12])
        else $error("drive code differs from active word");
    a_sector_map: assert property (act_rd |=> SECTOR_MAP == REG_RDATA[9:8])
        else $error("sector map differs from active word");
    a_latency_plus_five: assert property (act_rd |=>
        READ_LATENCY_CLKS == {1'b0, REG_RDATA[7:4]} + 5'h05)
        else $error("latency is not code plus five");
    a_stall_polarity: assert property (act_rd |=> STROBE_STALL_ON_DUAL_ERR != REG_RDATA[2])
        else $error("strobe stall polarity wrong");
    a_ssr_freeze: assert property (act_rd |=> SECURE_REGION_LOCKED != REG_RDATA[10])
        else $error("secure region lock polarity wrong");
    a_wrap_length: assert property (act_rd |=> WRAP_LEGACY == REG_RDATA[1] &&
        BURST_RESERVED == (REG_RDATA[1:0] == 2'h0) && WRAP_BYTES == (REG_RDATA[1:0] == 2'h1 ?
        7'h40 : REG_RDATA[1:0] == 2'h2 ? 7'h10 : REG_RDATA[1:0] == 2'h3 ? 7'h20 : 7'h00))
        else $error("wrap decode differs from burst code");
    a_reserved_ones: assert property (REG_RD && REG_ADDR inside {3'h0, 3'h1, 3'h3}
        |=> REG_RDATA[15] && REG_RDATA[3])
        else $error("reserved bit read back as zero");
    a_source_switch: assert property ($rose(CFG_FROM_VOLATILE) |-> $past(vol_wr))
        else $error("source switched without a volatile load");
    a_source_held: assert property ($fell(CFG_FROM_VOLATILE) |-> 1'b0)
        else $error("source returned to nonvolatile without reset");
    a_sw_reset_keeps: assert property (SW_RESET && !REG_WR
        |=> CFG_FROM_VOLATILE == $past(CFG_FROM_VOLATILE))
        else $error("software reset moved the source select");
    a_busy_refused: assert property (!DEV_IDLE && vol_wr && !CFG_FROM_VOLATILE
        |=> !CFG_FROM_VOLATILE [*2])
        else $error("load accepted while busy");
    a_lock_sticky: assert property (CFG_LOCKED |=> CFG_LOCKED)
        else $error("lock released without reset");

    // main scenarios reached
    c_vol_load: cover property (vol_wr && DEV_IDLE ##1 CFG_FROM_VOLATILE);
    c_locked: cover property (CFG_LOCKED && vol_wr);
    c_sw_reset: cover property (SW_RESET && CFG_FROM_VOLATILE);
endmodule : bcr_checker

bind bcr_top bcr_checker u_chk (.CLK(CLK), .RST_N(RST_N), .NV_INIT_N(NV_INIT_N),
    .SW_RESET(SW_RESET), .DEV_IDLE(DEV_IDLE), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CFG_FROM_VOLATILE(CFG_FROM_VOLATILE),
    .CFG_LOCKED(CFG_LOCKED), .SECURE_REGION_LOCKED(SECURE_REGION_LOCKED),
    .DRIVE_CODE(DRIVE_CODE), .SECTOR_MAP(SECTOR_MAP), .READ_LATENCY_CLKS(READ_LATENCY_CLKS),
    .STROBE_STALL_ON_DUAL_ERR(STROBE_STALL_ON_DUAL_ERR), .WRAP_BYTES(WRAP_BYTES),
    .WRAP_LEGACY(WRAP_LEGACY), .BURST_RESERVED(BURST_RESERVED));

// File: testbench/bcr_host_model.sv
// host controller model: master of the plain register port
// assumes the caller keeps the device idle unless a refusal is wanted
`timescale 1ns/1ps
module bcr_host_model
    import bcr_pkg::*;
(
    input wire logic clk,
    output logic [bcr_pkg::ADDR_W-1:0] reg_addr,
    output logic [bcr_pkg::CFG_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [bcr_pkg::CFG_W-1:0] reg_rdata
);
    ////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial
    begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write; released data is inverted so stale values never look valid
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [CFG_W-1:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask : wr

    // one-cycle read; data is taken once the read edge has landed
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [CFG_W-1:0] q);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask : rd
endmodule : bcr_host_model

// File: testbench/bcr_top_bench.sv
// self-checking bench for the configuration register pair
// assumes bcr_host_model drives the register port; resets and idle come from here
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        n_compared++; \
        if ((a) !== (b)) \
        begin \
            bad_count++; \
            $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); \
        end \
    end
module bcr_top_bench;
    import bcr_pkg::*;
    logic CLK, RST_N, NV_INIT_N, SW_RESET, DEV_IDLE, REG_WR, REG_RD;
    logic [2:0] REG_ADDR;
    logic [15:0] REG_WDATA, REG_RDATA, q, d;
    logic CFG_FROM_VOLATILE, CFG_LOCKED, SECURE_REGION_LOCKED, STROBE_STALL_ON_DUAL_ERR;
    logic [2:0] DRIVE_CODE;
    logic [1:0] SECTOR_MAP;
    logic [4:0] READ_LATENCY_CLKS;
    logic [6:0] WRAP_BYTES;
    logic WRAP_LEGACY, BURST_RESERVED;
    logic [31:0] seed = 32'h54FE;
    int bad_count = 0;
    int n_compared = 0;
    ////////////////////////////////////////////////////////////
    bcr_top DUT (.CLK(CLK), .RST_N(RST_N), .NV_INIT_N(NV_INIT_N), .SW_RESET(SW_RESET),
        .DEV_IDLE(DEV_IDLE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CFG_FROM_VOLATILE(CFG_FROM_VOLATILE),
        .CFG_LOCKED(CFG_LOCKED), .SECURE_REGION_LOCKED(SECURE_REGION_LOCKED),
        .DRIVE_CODE(DRIVE_CODE), .SECTOR_MAP(SECTOR_MAP), .READ_LATENCY_CLKS(READ_LATENCY_CLKS),
        .STROBE_STALL_ON_DUAL_ERR(STROBE_STALL_ON_DUAL_ERR), .WRAP_BYTES(WRAP_BYTES),
        .WRAP_LEGACY(WRAP_LEGACY), .BURST_RESERVED(BURST_RESERVED));
    bcr_host_model host (.clk(CLK), .reg_addr(REG_ADDR), .reg_wdata(REG_WDATA),
        .reg_wr(REG_WR), .reg_rd(REG_RD), .reg_rdata(REG_RDATA));

    // 250 MHz clock
    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift

    function automatic logic [6:0] wrap_of(input logic [1:0] c);
        return c == BURST_64 ? WRAP_BYTES_64 : c == BURST_16 ? WRAP_BYTES_16 :
            c == BURST_32 ? WRAP_BYTES_32 : WRAP_BYTES_NONE;
    endfunction : wrap_of

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    // hardware reset held three cycles; decoded outputs settle one edge later
    task automatic hw_reset();
        @(posedge CLK) RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (2) @(posedge CLK);
        #1;
    endtask : hw_reset

    // write, then wait until the decoded outputs carry its effect
    task automatic ld(input logic [2:0] a, input logic [15:0] v);
        host.wr(a, v);
        repeat (2) @(posedge CLK);
        #1;
    endtask : ld

    task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
        host.rd(a, q);
        `CHK(q, e)
    endtask : rd_chk

    task automatic chk_dec(input logic [15:0] w);
        `CHK(DRIVE_CODE, w[14:12])
        `CHK(SECTOR_MAP, w[9:8])
        `CHK(READ_LATENCY_CLKS, {1'b0, w[7:4]} + LAT_BASE)
        `CHK(STROBE_STALL_ON_DUAL_ERR, ~w[BIT_STALL])
        `CHK(SECURE_REGION_LOCKED, ~w[BIT_SSR])
        `CHK(WRAP_BYTES, wrap_of(w[1:0]))
        `CHK(WRAP_LEGACY, w[1])
        `CHK(BURST_RESERVED, w[1:0] == BURST_RSVD)
    endtask : chk_dec

    // watchdog well beyond the some 155 cycles the sequence needs
    initial
    begin
        repeat (3000) @(posedge CLK);
        bad_count++;
        conclude();
    end

    initial
    begin
        RST_N = 1'b0;
        NV_INIT_N = 1'b0;
        SW_RESET = 1'b0;
        DEV_IDLE = 1'b1;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        NV_INIT_N <= 1'b1;
        repeat (2) @(posedge CLK);
        #1;
        chk_dec(CFG_FACTORY);
        rd_chk(OFF_NV_CFG, CFG_FACTORY);
        rd_chk(OFF_STATUS, 16'h0000);
        rd_chk(3'h5, RDATA_IDLE);
        // a load while busy is refused and flagged
        @(posedge CLK) DEV_IDLE <= 1'b0;
        ld(OFF_VOL_CFG, 16'h8A5B);
        @(posedge CLK) DEV_IDLE <= 1'b1;
        #1;
        `CHK(CFG_FROM_VOLATILE, 1'b0)
        rd_chk(OFF_VOL_CFG, CFG_FACTORY);
        rd_chk(OFF_STATUS, 16'h0010);
        // programming before any load: volatile copy follows, behaviour waits for reset
        ld(OFF_NV_CFG, 16'h8A5B);
        chk_dec(CFG_FACTORY);
        rd_chk(OFF_VOL_CFG, 16'h8A5B);
        hw_reset();
        chk_dec(16'h8A5B);
        rd_chk(OFF_STATUS, 16'h0020);
        // random loads covering every drive and burst code, reserved bits random
        for (int i = 0; i < 8; i++)
        begin
            seed = xorshift(seed);
            d = (seed[15:0] & 16'h87FC) | {1'b0, i[2:0], 12'h800} | {14'h0, i[1:0]};
            ld(OFF_VOL_CFG, d);
            `CHK(CFG_FROM_VOLATILE, 1'b1)
            chk_dec(d | CFG_RSVD_MASK);
            rd_chk(OFF_VOL_CFG, d | CFG_RSVD_MASK);
            rd_chk(OFF_ACTIVE_CFG, d | CFG_RSVD_MASK);
        end
        // programming after a load leaves the loaded copy in charge
        ld(OFF_NV_CFG, CFG_FACTORY);
        chk_dec(d | CFG_RSVD_MASK);
        rd_chk(OFF_VOL_CFG, d | CFG_RSVD_MASK);
        @(posedge CLK) SW_RESET <= 1'b1;
        @(posedge CLK) SW_RESET <= 1'b0;
        #1;
        `CHK(CFG_FROM_VOLATILE, 1'b1)
        // freeze through the volatile copy, then a refused load
        ld(OFF_VOL_CFG, 16'h86BB);
        `CHK(CFG_LOCKED, 1'b1)
        ld(OFF_VOL_CFG, CFG_FACTORY);
        rd_chk(OFF_VOL_CFG, 16'h86BB);
        rd_chk(OFF_STATUS, 16'h0017);
        hw_reset();
        `CHK(CFG_LOCKED, 1'b0)
        `CHK(CFG_FROM_VOLATILE, 1'b0)
        // an erase before any load drags the volatile copy along
        ld(OFF_NV_ERASE, 16'h0000);
        rd_chk(OFF_NV_CFG, CFG_ERASED);
        rd_chk(OFF_VOL_CFG, CFG_ERASED);
        // freeze programmed into the nonvolatile copy only bites after reset
        ld(OFF_NV_CFG, 16'h86BB);
        `CHK(CFG_LOCKED, 1'b0)
        hw_reset();
        rd_chk(OFF_STATUS, 16'h000C);
        ld(OFF_NV_CFG, CFG_FACTORY);
        ld(OFF_NV_ERASE, 16'h0000);
        rd_chk(OFF_NV_CFG, 16'h86BB);
        conclude();
    end
endmodule : bcr_top_bench
